// [hdl/rca_cfg.svh]
`ifndef RCA_CFG_SVH
`define RCA_CFG_SVH
// Function
// - At most one source, the analog port or one digital interface, owns remote control.
// - A digital remote request during analog remote control is refused with an error.
// - The analog request pin going active while a digital owner exists is ignored.
// - Status and value reads are served from every interface whatever the owner.
// - Without owner or lock the device is manual and both kinds may request control.
// - Clearing the remote permit enters local lock, where every remote request is refused.
// - Local lock ends a digital session at once and it stays ended until a new request.
// - Local lock only suspends analog control, which resumes if the pin is still active.
// - The watchdog watches only the owning digital interface and idles otherwise.
// - Each message from the owner restarts the watchdog; the host must send in time.
// - Watchdog expiry releases remote control back to manual.
// - On expiry with the output on, the state-after-remote setting decides output off.
// - A new timeout takes effect only once the running period has ended.
// - The watchdog is independent of the network connection timeout.

`define RCA_ADDR_W 8
`define RCA_OFF_CTRL 8'h00
`define RCA_OFF_WDTO 8'h04
`define RCA_OFF_STAT 8'h08
`define RCA_OFF_ISTAT 8'h0c
`define RCA_OFF_IMASK 8'h10

`define RCA_CTRL_ALLOW 0
`define RCA_CTRL_SAROFF 1
`define RCA_ALLOW_RST 1'h1
`define RCA_SAROFF_RST 1'h1

`define RCA_WDTO_W 16
`define RCA_WDTO_RST 16'h0000

`define RCA_STAT_OWN_LSB 0
`define RCA_STAT_IDX_LSB 4
`define RCA_STAT_PIN 8
`define RCA_STAT_WDRUN 9

`define RCA_IRQ_W 4
`define RCA_IRQ_WDEXP 0
`define RCA_IRQ_REFUSE 1
`define RCA_IRQ_LOCK 2
`define RCA_IRQ_OWNCHG 3
`define RCA_IMASK_RST 4'h0

`define RCA_SYNC_RST 2'h3

`define RCA_CLK_NS 8
`define RCA_WD_UNIT_NS 1000000
`define RCA_WD_TICK_CYC (`RCA_WD_UNIT_NS / `RCA_CLK_NS)

`endif

// [hdl/rca_pkg.sv]
package rca_pkg;

	typedef enum logic [1:0] {
		RCA_MANUAL,
		RCA_ANALOG,
		RCA_DIGITAL,
		RCA_LOCAL
	} rca_owner_t;

endpackage : rca_pkg

// [hdl/rca_wd_if.sv]
`timescale 1ns/1ns
`include "rca_cfg.svh"

interface rca_wd_if;
	logic run;
	logic kick;
	logic [`RCA_WDTO_W-1:0] to_val;
	logic expired;

	modport ctl (
		output run,
		output kick,
		output to_val,
		input expired
	);

	modport tmr (
		input run,
		input kick,
		input to_val,
		output expired
	);
endinterface : rca_wd_if

// [hdl/rca_wdog.sv]
`timescale 1ns/1ns
`include "rca_cfg.svh"

module rca_wdog #(
	parameter int TICK_CYC = `RCA_WD_TICK_CYC
) (
	input wire logic clk,
	input wire logic rst,
	rca_wd_if.tmr wd
);
	localparam int PW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

	initial begin
		if (TICK_CYC < 1) begin
			$error("rca_wdog: TICK_CYC must be at least one");
		end
	end

	typedef struct packed {
		logic [PW-1:0] pre;
		logic [`RCA_WDTO_W-1:0] ms;
		logic [`RCA_WDTO_W-1:0] cur;
		logic expired;
	} rca_wd_st_t;

	rca_wd_st_t s_q;
	rca_wd_st_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.expired = 1'b0;
		// Only the network connection timer lives elsewhere; nothing here
		// looks at it, so both may run and expire on their own.
		if (!wd.run) begin
			s_d.pre = '0;
			s_d.ms = '0;
			s_d.cur = wd.to_val;
		end else if (wd.kick) begin
			s_d.pre = '0;
			s_d.ms = '0;
			s_d.cur = wd.to_val;
		end else if (s_q.cur != '0) begin
			if (s_q.pre == PW'(TICK_CYC - 1)) begin
				s_d.pre = '0;
				if (s_q.ms == s_q.cur - 1'b1) begin
					s_d.expired = 1'b1;
					s_d.ms = '0;
					s_d.cur = wd.to_val;
				end else begin
					s_d.ms = s_q.ms + 1'b1;
				end
			end else begin
				s_d.pre = s_q.pre + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign wd.expired = s_q.expired;

endmodule : rca_wdog

// [hdl/rca_top.sv]
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "rca_cfg.svh"

module rca_top
	import rca_pkg::*;
#(
	parameter int NIF = 4,
	parameter int TICK_CYC = `RCA_WD_TICK_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`RCA_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic ana_remote_n,
	input wire logic [NIF-1:0] dig_req,
	input wire logic [NIF-1:0] dig_rel,
	input wire logic [NIF-1:0] dig_ctrl,
	input wire logic [NIF-1:0] dig_msg,
	input wire logic dc_on,
	output logic [NIF-1:0] dig_ok,
	output logic [NIF-1:0] dig_err,
	output logic dc_off,
	output logic ana_ctl,
	output logic [1:0] owner,
	output logic [2:0] owner_idx,
	output logic irq
);
	// The owner index is three bits wide, so eight interfaces at most.
	initial begin
		if (NIF < 1 || NIF > 8) begin
			$error("rca_top: NIF must lie between 1 and 8");
		end
		if (TICK_CYC < 1) begin
			$error("rca_top: TICK_CYC must be at least one");
		end
	end

	// Synchroniser, owner, settings and the one-cycle answers are one
	// record, so that they always move on the same edge.
	typedef struct packed {
		logic [1:0] pin;
		rca_owner_t own;
		logic [2:0] idx;
		logic allow;
		logic sar_off;
		logic [`RCA_WDTO_W-1:0] wdto;
		logic [`RCA_IRQ_W-1:0] ist;
		logic [`RCA_IRQ_W-1:0] imask;
		logic [31:0] rdata;
		logic [NIF-1:0] ok;
		logic [NIF-1:0] err;
		logic dc_off;
		logic ana_ctl;
		logic irq;
	} rca_top_st_t;

	rca_top_st_t s_q;
	rca_top_st_t s_d;

	// The timer is a block of its own, so that its prescaler can be made
	// short for simulation without touching the arbitration.
	rca_wd_if wd_if ();

	rca_wdog #(
		.TICK_CYC(TICK_CYC)
	) u_wdog (
		.clk(clk),
		.rst(rst),
		.wd(wd_if)
	);

	// Lowest requesting interface wins when several ask in the same cycle.
	function automatic logic [2:0] first_set(input logic [NIF-1:0] v);
		logic [2:0] r;
		r = '0;
		for (int i = NIF - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : first_set

	// The index field reads zero unless a digital owner exists, so that
	// software never acts on the index of an ended session.
	function automatic logic [31:0] status_word(input rca_top_st_t s,
		input logic pin_req, input logic wd_run);
		logic [31:0] r;
		r = '0;
		r[`RCA_STAT_OWN_LSB +: 2] = s.own;
		r[`RCA_STAT_IDX_LSB +: 3] = (s.own == RCA_DIGITAL) ? s.idx : 3'h0;
		r[`RCA_STAT_PIN] = pin_req;
		r[`RCA_STAT_WDRUN] = wd_run;
		return r;
	endfunction : status_word

	// True while interface i holds the digital session in state s; used
	// for kicks, releases and every accept or refuse decision.
	function automatic logic owns(input rca_top_st_t s, input int i);
		return (s.own == RCA_DIGITAL) && (s.idx == 3'(i));
	endfunction : owns

	logic ana_req;
	logic lock;
	logic grant;
	logic [2:0] gidx;
	logic kick;
	logic [`RCA_IRQ_W-1:0] ev;

	// Only the second synchroniser stage is read; the pin is active low
	// and the reset value of the chain reads as manual.
	assign ana_req = ~s_q.pin[1];
	assign lock = ~s_q.allow;
	assign gidx = first_set(dig_req);
	// A digital request can win only from plain manual with the pin idle.
	assign grant = (s_q.own == RCA_MANUAL) && !lock && !ana_req
		&& (|dig_req);

	always_comb begin
		kick = 1'b0;
		for (int i = 0; i < NIF; i++) begin
			if (owns(s_q, i) && dig_msg[i]) begin
				kick = 1'b1;
			end
		end
	end

	// Run follows ownership alone: the status bit shows a supervised
	// session even while a zero timeout keeps the timer from counting.
	assign wd_if.run = (s_q.own == RCA_DIGITAL);
	assign wd_if.kick = kick;
	assign wd_if.to_val = s_q.wdto;

	always_comb begin
		s_d = s_q;
		ev = '0;
		s_d.pin = {s_q.pin[0], ana_remote_n};
		s_d.ok = '0;
		s_d.err = '0;
		s_d.dc_off = 1'b0;

		case (s_q.own)
			RCA_MANUAL: begin
				// Analog wins a tie with a digital request: the pin is a
				// wire that cannot be told it lost, the host gets an error.
				if (lock) begin
					s_d.own = RCA_LOCAL;
				end else if (ana_req) begin
					s_d.own = RCA_ANALOG;
				end else if (grant) begin
					s_d.own = RCA_DIGITAL;
					s_d.idx = gidx;
				end
			end
			RCA_ANALOG: begin
				if (lock) begin
					s_d.own = RCA_LOCAL;
				end else if (!ana_req) begin
					s_d.own = RCA_MANUAL;
				end
			end
			RCA_DIGITAL: begin
				if (lock) begin
					s_d.own = RCA_LOCAL;
				end else if (wd_if.expired) begin
					s_d.own = RCA_MANUAL;
					s_d.dc_off = s_q.sar_off & dc_on;
					ev[`RCA_IRQ_WDEXP] = 1'b1;
				end else begin
					// The pin is not looked at here, so a digital owner
					// keeps control whatever the analog side does.
					for (int i = 0; i < NIF; i++) begin
						if (owns(s_q, i) && dig_rel[i]) begin
							s_d.own = RCA_MANUAL;
						end
					end
				end
			end
			RCA_LOCAL: begin
				if (!lock) begin
					// Analog resumes by pin level; a digital owner must
					// request afresh.
					s_d.own = ana_req ? RCA_ANALOG : RCA_MANUAL;
				end
			end
			default: begin
				s_d.own = RCA_MANUAL;
			end
		endcase

		for (int i = 0; i < NIF; i++) begin
			// Requests and control actions are arbitrated; plain reads and
			// other messages never reach this path.
			if (dig_req[i]) begin
				// Accepted only if the interface owns the session after
				// this cycle, so an answer never contradicts an expiry, a
				// release or a lock in the same cycle.
				if (owns(s_d, i)) begin
					s_d.ok[i] = 1'b1;
				end else begin
					s_d.err[i] = 1'b1;
				end
			end
			if (dig_ctrl[i]) begin
				if (owns(s_q, i) && owns(s_d, i)) begin
					s_d.ok[i] = 1'b1;
				end else begin
					s_d.err[i] = 1'b1;
				end
			end
		end

		ev[`RCA_IRQ_REFUSE] = |s_d.err;
		// Lock entry is reported once, in the cycle that leaves the owner.
		ev[`RCA_IRQ_LOCK] = lock && (s_q.own != RCA_LOCAL);
		ev[`RCA_IRQ_OWNCHG] = (s_d.own != s_q.own);

		if (wr) begin
			case (addr)
				`RCA_OFF_CTRL: begin
					// A cleared permit acts through the lock term from the
					// next cycle on, so the owner logic sees it one cycle after the write.
					s_d.allow = wdata[`RCA_CTRL_ALLOW];
					s_d.sar_off = wdata[`RCA_CTRL_SAROFF];
				end
				`RCA_OFF_WDTO: begin
					// The timer samples this only while idle or at a period boundary, so
					// the register itself acts as the pending value.
					s_d.wdto = wdata[`RCA_WDTO_W-1:0];
				end
				`RCA_OFF_IMASK: begin
					s_d.imask = wdata[`RCA_IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Read data stands for one cycle only; between reads the port
		// shows zero, so a late sample cannot pick up a stale word.
		s_d.rdata = '0;
		if (rd) begin
			case (addr)
				`RCA_OFF_CTRL: begin
					s_d.rdata[`RCA_CTRL_ALLOW] = s_q.allow;
					s_d.rdata[`RCA_CTRL_SAROFF] = s_q.sar_off;
				end
				`RCA_OFF_WDTO: begin
					s_d.rdata[`RCA_WDTO_W-1:0] = s_q.wdto;
				end
				`RCA_OFF_STAT: begin
					s_d.rdata = status_word(s_q, ana_req, wd_if.run);
				end
				`RCA_OFF_ISTAT: begin
					s_d.rdata[`RCA_IRQ_W-1:0] = s_q.ist;
				end
				`RCA_OFF_IMASK: begin
					s_d.rdata[`RCA_IRQ_W-1:0] = s_q.imask;
				end
				default: begin
				end
			endcase
		end

		// A new event in the clearing cycle survives the read-clear.
		if (rd && addr == `RCA_OFF_ISTAT) begin
			s_d.ist = ev;
		end else begin
			s_d.ist = s_q.ist | ev;
		end

		s_d.ana_ctl = (s_d.own == RCA_ANALOG);
		s_d.irq = |(s_d.ist & s_d.imask);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			// The chain resets to the idle high level, so leaving reset
			// never looks like an analog request.
			s_q.pin <= `RCA_SYNC_RST;
			s_q.own <= RCA_MANUAL;
			s_q.allow <= `RCA_ALLOW_RST;
			s_q.sar_off <= `RCA_SAROFF_RST;
			s_q.wdto <= `RCA_WDTO_RST;
			s_q.imask <= `RCA_IMASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign dig_ok = s_q.ok;
	assign dig_err = s_q.err;
	assign dc_off = s_q.dc_off;
	assign ana_ctl = s_q.ana_ctl;
	assign owner = s_q.own;
	assign owner_idx = s_q.idx;
	assign irq = s_q.irq;

endmodule : rca_top

// [sim/rca_host.sv]
`timescale 1ns/1ns

module rca_host #(
	parameter int NIF = 4,
	parameter int IDX = 1
) (
	input wire logic clk,
	input wire logic en,
	input wire logic [7:0] per,
	output logic [NIF-1:0] msg
);
	logic [7:0] cnt_q;

	// A live host sends a message every per+1 cycles, inside the timeout.
	always_ff @(posedge clk) begin
		msg <= '0;
		if (!en || cnt_q == per)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_q + 8'h01;
		if (en && cnt_q == per)
			msg[IDX] <= 1'b1;
	end
endmodule : rca_host

// [sim/rca_top_chk.sv]
`timescale 1ns/1ns
`include "rca_cfg.svh"

module rca_chk
	import rca_pkg::*;
#(
	parameter int NIF = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`RCA_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic [NIF-1:0] dig_req,
	input wire logic [NIF-1:0] dig_ctrl,
	input wire logic dc_on,
	input wire logic [NIF-1:0] dig_ok,
	input wire logic [NIF-1:0] dig_err,
	input wire logic dc_off,
	input wire logic ana_ctl,
	input wire logic [1:0] owner,
	input wire logic [2:0] owner_idx
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_req_refused: assert property (
		(owner == RCA_ANALOG || owner == RCA_LOCAL) && dig_req[0]
		|=> dig_err[0] && !dig_ok[0]) else $error("request not refused");
	a_busy_owner: assert property (
		owner == RCA_DIGITAL && owner_idx != 3'h0 && dig_req[0]
		|=> dig_err[0]) else $error("second digital owner");
	a_ctl_refused: assert property (
		dig_ctrl[0] && !(owner == RCA_DIGITAL && owner_idx == 3'h0)
		|=> dig_err[0]) else $error("foreign control accepted");
	a_ok_owner: assert property (
		dig_ok[1] |-> owner == RCA_DIGITAL && owner_idx == 3'h1)
		else $error("grant without owner");
	a_no_steal: assert property (
		owner == RCA_DIGITAL |=> owner != RCA_ANALOG)
		else $error("analog took digital session");
	a_lock_enter: assert property (
		wr && addr == `RCA_OFF_CTRL && !wdata[`RCA_CTRL_ALLOW]
		|-> ##2 owner == RCA_LOCAL) else $error("lock not entered");
	a_ana_flag: assert property (
		ana_ctl == (owner == RCA_ANALOG)) else $error("analog flag off");
	a_dcoff_cause: assert property (
		dc_off |-> owner == RCA_MANUAL && $past(owner) == RCA_DIGITAL
		&& $past(dc_on)) else $error("stray output off");

	c_grant: cover property (dig_ok[1]);
	c_analog: cover property (ana_ctl);
	c_expiry: cover property (dc_off);
endmodule : rca_chk

bind rca_top rca_chk #(.NIF(NIF)) rca_chk_inst (
	.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
	.dig_req(dig_req), .dig_ctrl(dig_ctrl), .dc_on(dc_on),
	.dig_ok(dig_ok), .dig_err(dig_err), .dc_off(dc_off),
	.ana_ctl(ana_ctl), .owner(owner), .owner_idx(owner_idx));

// [sim/tb_remote_control_arbiter.sv]
`timescale 1ns/1ns
`include "rca_cfg.svh"

module tb_remote_control_arbiter
	import rca_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic ana_n = 1'b1, dc_on = 1'b0, hen = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] req = 4'h0, ctl = 4'h0, rel = 4'h0, msg, ok, err;
	logic dc_off, ana_ctl, irq;
	logic [1:0] owner;
	logic [2:0] idx;
	int n_fail = 0, tests_run = 0, n_off = 0;

	always #4 clk = ~clk;
	always @(posedge clk) if (dc_off === 1'b1) n_off++;

	rca_top #(.NIF(4), .TICK_CYC(4)) rca_top_inst (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .ana_remote_n(ana_n), .dig_req(req), .dig_rel(rel),
		.dig_ctrl(ctl), .dig_msg(msg), .dc_on(dc_on), .dig_ok(ok),
		.dig_err(err), .dc_off(dc_off), .ana_ctl(ana_ctl), .owner(owner),
		.owner_idx(idx), .irq(irq));
	rca_host #(.NIF(4), .IDX(1)) rca_host_inst (
		.clk(clk), .en(hen), .per(8'h05), .msg(msg));

	task give_verdict;
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	task check(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %0t: got %h exp %h", $time, s, e);
		end
	endtask : check

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	task rreg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, e);
	endtask : rreg

	// Pulses a request or control action and checks the ok/err answer.
	task act(input int i, input logic c, input logic [1:0] e);
		@(posedge clk);
		if (c)
			ctl[i] <= 1'b1;
		else
			req[i] <= 1'b1;
		@(posedge clk);
		ctl <= 4'h0;
		req <= 4'h0;
		#1;
		check({30'h0, ok[i], err[i]}, {30'h0, e});
	endtask : act

	task own(input logic [1:0] o);
		check({30'h0, owner}, {30'h0, o});
	endtask : own

	// Pulses a leave-remote message from interface i.
	task rls(input int i);
		@(posedge clk);
		rel[i] <= 1'b1;
		@(posedge clk);
		rel <= 4'h0;
		#1;
	endtask : rls

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rreg(`RCA_OFF_STAT, 32'h0);
		rreg(`RCA_OFF_CTRL, 32'h3);
		rreg(8'h40, 32'h0);
		act(1, 1'b0, 2'b10);
		check({29'h0, idx}, 32'h1);
		act(0, 1'b0, 2'b01);
		act(0, 1'b1, 2'b01);
		act(1, 1'b1, 2'b10);
		@(posedge clk);
		ana_n <= 1'b0;
		cyc(6);
		own(RCA_DIGITAL);
		rreg(`RCA_OFF_STAT, 32'h312);
		wreg(`RCA_OFF_CTRL, 32'h2);
		cyc(2);
		own(RCA_LOCAL);
		act(1, 1'b0, 2'b01);
		wreg(`RCA_OFF_CTRL, 32'h3);
		cyc(4);
		own(RCA_ANALOG);
		check({31'h0, ana_ctl}, 32'h1);
		act(2, 1'b0, 2'b01);
		@(posedge clk);
		ana_n <= 1'b1;
		cyc(5);
		own(RCA_MANUAL);
		rreg(`RCA_OFF_ISTAT, 32'he);
		wreg(`RCA_OFF_WDTO, 32'h3);
		wreg(`RCA_OFF_IMASK, 32'h1);
		dc_on <= 1'b1;
		act(1, 1'b0, 2'b10);
		@(posedge clk);
		hen <= 1'b1;
		cyc(40);
		own(RCA_DIGITAL);
		check({31'h0, irq}, 32'h0);
		@(posedge clk);
		hen <= 1'b0;
		// The longer timeout must wait for the running period to end.
		wreg(`RCA_OFF_WDTO, 32'h64);
		cyc(16);
		own(RCA_MANUAL);
		check(n_off, 32'h1);
		check({31'h0, irq}, 32'h1);
		rreg(`RCA_OFF_ISTAT, 32'h9);
		cyc(2);
		check({31'h0, irq}, 32'h0);
		act(1, 1'b0, 2'b10);
		rls(2);
		own(RCA_DIGITAL);
		rls(1);
		own(RCA_MANUAL);
		give_verdict();
	end

	initial begin
		repeat (3000) @(posedge clk);
		n_fail++;
		give_verdict();
	end
endmodule : tb_remote_control_arbiter
